// *** rtl/adc_readout_pkg.sv ***
// Constants and types shared by the scaled ADC readout block
// Overview of operation
// RULE1: Three independent 12-bit conversion channels each feed their own result register.
// RULE2: The channel results sit at offsets 0x14, 0x16 and 0x18 of the status set, one per channel.
// RULE3: Every channel is converted once per 250 us and each conversion takes 3.5 us.
// RULE4: Each result register is refreshed once every 2000 us, a 500 Hz output rate.
// RULE5: Samples pass an average that drops the largest and smallest values, then a low-pass filter.
// RULE6: In scaled mode channel zero reports BCD tenths of a millivolt over a fixed 5.2 V full scale; the code saturates anything past 9999 at 0x9999.
// RULE7: Only channels one and two take the 10 V, 20 V or 30 V scales; channel zero stays at 5.2 V.
// RULE8: The scale-select byte sits at offset 0x08 of the settings set and reads back its current value.
// RULE9: The upper nibble picks the channel-one scale: 0 for 5.2 V, 1 for 10 V, 2 for 20 V, 3 for 30 V.
// RULE10: The lower nibble picks the channel-two scale: 0 for 5.2 V, 1 for 10 V, 2 for 20 V, 3 for 30 V.
// RULE11: Any pair of valid nibble codes is accepted and the two channel scales act independently.
// RULE12: Writing 0xFF to the scale-select byte turns all three results into raw counts.
// RULE13: In raw mode a result is a plain 12-bit count from 0 to 4095.
// RULE14: The scale-select byte resets to 0x00, all channels scaled over 0 to 5.2 V.
// RULE15: The host writes the scale code that matches the external divider it fits.
// RULE16: Result registers are read-only 16-bit words; writes are ignored and reads are never torn.
// RULE17: Writes carrying an undefined nibble code, other than the full raw byte, are ignored.
package adc_readout_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   // Sampling timing
   localparam int unsigned SAMPLE_PERIOD_NS = 250_000;
   localparam int unsigned CONV_TIME_PS = 3_500_000;
   localparam int unsigned PUBLISH_PERIOD_NS = 2_000_000;
   localparam int unsigned SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned CONV_CYCLES = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PUBLISH_CYCLES = (PUBLISH_PERIOD_NS / 1000) * (CLK_HZ / 1_000_000);
   localparam int unsigned SAMPLES_PER_PUBLISH = PUBLISH_CYCLES / SAMPLE_CYCLES;
   // Register map
   localparam logic [7:0] SCALE_SEL_OFFSET = 8'h08;
   localparam logic [7:0] CH0_RESULT_OFFSET = 8'h14;
   localparam logic [7:0] CH1_RESULT_OFFSET = 8'h16;
   localparam logic [7:0] CH2_RESULT_OFFSET = 8'h18;
   localparam logic [7:0] SCALE_SEL_RESET = 8'h00;
   localparam logic [7:0] SCALE_RAW_CODE = 8'hff;
   localparam logic [3:0] SCALE_MAX_CODE = 4'h3;
   localparam int unsigned CH1_NIBBLE_LSB = 4;
   localparam int unsigned CH2_NIBBLE_LSB = 0;
   // Data widths
   localparam int unsigned ADC_BITS = 12;
   localparam int unsigned NUM_CH = 3;
   localparam logic [11:0] ADC_MAX = 12'hfff;
   localparam int unsigned LPF_SHIFT = 2;
   // Full scale in tenths of millivolts, per scale code
   localparam logic [18:0] FS_5V2 = 19'h0cb20;
   localparam logic [18:0] FS_10V = 19'h186a0;
   localparam logic [18:0] FS_20V = 19'h30d40;
   localparam logic [18:0] FS_30V = 19'h493e0;
   localparam logic [15:0] BCD_SAT = 16'h9999;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } settings_req_t;

   typedef struct packed {
      logic rd;
      logic [7:0] addr;
   } status_req_t;
endpackage

// *** rtl/adc_scaled_readout.sv ***
// Three-channel ADC sampler, filter, scaler and register sets
`timescale 1ns/1ps
`default_nettype none
module adc_scaled_readout (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Converter interface
   output logic o_conv_start,
   output logic [1:0] o_conv_chan,
   input wire logic i_conv_done,
   input wire logic [11:0] i_conv_data,
   // Settings register set, byte wide
   input wire adc_readout_pkg::settings_req_t i_set_req,
   output logic [7:0] o_set_rdata,
   output logic o_set_rvalid,
   // Status register set, word wide
   input wire adc_readout_pkg::status_req_t i_stat_req,
   output logic [15:0] o_stat_rdata,
   output logic o_stat_rvalid
);
   typedef enum logic [1:0] {S_IDLE, S_CONV, S_WAIT} conv_state_t;

   logic [7:0] scale_q;
   conv_state_t state_q;
   conv_state_t state_d;
   logic [31:0] tick_q;
   logic [1:0] chan_q;
   logic start_q;
   logic [7:0] set_rdata_q;
   logic set_rvalid_q;
   logic [15:0] stat_rdata_q;
   logic stat_rvalid_q;

   wire period_tick = (tick_q == 32'(adc_readout_pkg::SAMPLE_CYCLES - 1));
   wire [3:0] nib_hi = i_set_req.wdata[7:4];
   wire [3:0] nib_lo = i_set_req.wdata[3:0];
   wire set_sel = i_set_req.addr == adc_readout_pkg::SCALE_SEL_OFFSET;
   wire code_raw = i_set_req.wdata == adc_readout_pkg::SCALE_RAW_CODE;
   wire code_ok = (nib_hi <= adc_readout_pkg::SCALE_MAX_CODE) && (nib_lo <= adc_readout_pkg::SCALE_MAX_CODE);
   wire scale_we = i_set_req.wr && set_sel && (code_raw || code_ok); // RULE11 RULE17
   wire raw_mode = scale_q == adc_readout_pkg::SCALE_RAW_CODE; // RULE12

   // Sample pacing: each 250 us slot converts the three channels back to back
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_q <= 32'h0;
      end else begin
         tick_q <= period_tick ? 32'h0 : tick_q + 32'h1; // RULE3
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (period_tick) begin
               state_d = S_CONV;
            end
         end
         S_CONV: begin
            state_d = S_WAIT;
         end
         S_WAIT: begin
            if (i_conv_done) begin
               state_d = (chan_q == 2'(adc_readout_pkg::NUM_CH - 1)) ? S_IDLE : S_CONV;
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= S_IDLE;
         chan_q <= 2'h0;
         start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         start_q <= state_d == S_CONV && state_q != S_CONV; // RULE3
         if (state_q == S_IDLE && period_tick) begin
            chan_q <= 2'h0;
         end else if (state_q == S_WAIT && i_conv_done && state_d == S_CONV) begin
            chan_q <= chan_q + 2'h1;
         end
      end
   end

   wire sample_valid = state_q == S_WAIT && i_conv_done;

   // Per channel: olympic average over the publish window, low-pass, scale, publish
   logic [15:0] result_w [adc_readout_pkg::NUM_CH];
   genvar g;
   generate
      for (g = 0; g < adc_readout_pkg::NUM_CH; g++) begin : g_ch
         logic [18:0] sum_q;
         logic [11:0] min_q;
         logic [11:0] max_q;
         logic [3:0] cnt_q;
         logic [13:0] lpf_q;
         logic [15:0] res_q;
         logic [3:0] code;
         logic [18:0] fs;
         logic [18:0] trimmed;
         logic [11:0] avg;
         logic [11:0] filt;
         logic [30:0] prod;
         logic [18:0] tenths;
         logic [15:0] bcd;
         logic [15:0] pub;
         wire hit = sample_valid && chan_q == 2'(g); // RULE1
         wire last = hit && cnt_q == 4'(adc_readout_pkg::SAMPLES_PER_PUBLISH - 1); // RULE4

         // Channel zero is hard-wired to the base scale
         assign code = (g == 1) ? scale_q[7:4] : (g == 2) ? scale_q[3:0] : 4'h0; // RULE7 RULE9 RULE10
         assign fs = (code == 4'h1) ? adc_readout_pkg::FS_10V :
                     (code == 4'h2) ? adc_readout_pkg::FS_20V :
                     (code == 4'h3) ? adc_readout_pkg::FS_30V : adc_readout_pkg::FS_5V2; // RULE6
         // Window sum minus the extremes, the current sample included
         assign trimmed = sum_q + 19'(i_conv_data) - 19'(max_q > i_conv_data ? max_q : i_conv_data)
                          - 19'(min_q < i_conv_data ? min_q : i_conv_data); // RULE5
         assign avg = 12'(trimmed / 19'(adc_readout_pkg::SAMPLES_PER_PUBLISH - 2));
         // First-order IIR with fractional bits kept in lpf_q
         assign filt = lpf_q[13:2];
         assign prod = 31'(filt) * 31'(fs);
         assign tenths = 19'(prod / 31'(adc_readout_pkg::ADC_MAX));
         // Four digits; values past 9999 saturate rather than wrap
         assign bcd = (tenths > 19'd9999) ? adc_readout_pkg::BCD_SAT :
                      {4'(tenths / 1000), 4'((tenths / 100) % 10), 4'((tenths / 10) % 10), 4'(tenths % 10)};
         assign pub = raw_mode ? {4'h0, filt} : bcd; // RULE12 RULE13

         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               sum_q <= 19'h0;
               min_q <= adc_readout_pkg::ADC_MAX;
               max_q <= 12'h0;
               cnt_q <= 4'h0;
               lpf_q <= 14'h0;
            end else if (last) begin
               sum_q <= 19'h0;
               min_q <= adc_readout_pkg::ADC_MAX;
               max_q <= 12'h0;
               cnt_q <= 4'h0;
               lpf_q <= 14'(lpf_q - (lpf_q >> adc_readout_pkg::LPF_SHIFT) + 14'(avg)); // RULE5
            end else if (hit) begin
               sum_q <= sum_q + 19'(i_conv_data);
               min_q <= (i_conv_data < min_q) ? i_conv_data : min_q;
               max_q <= (i_conv_data > max_q) ? i_conv_data : max_q;
               cnt_q <= cnt_q + 4'h1;
            end
         end

         // Result updates in one cycle as a whole word, so a read never sees halves
         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               res_q <= 16'h0;
            end else begin
               res_q <= pub; // RULE16
            end
         end
         assign result_w[g] = res_q;

         // Per-channel checks
         win_count_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE4
            hit
            |=> cnt_q <= 4'(adc_readout_pkg::SAMPLES_PER_PUBLISH - 1))
            else $error("window count overran");

         win_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE4
            last
            |=> cnt_q == 4'h0 && sum_q == 19'h0)
            else $error("window not restarted after publish");

         win_order_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE5
            cnt_q != 4'h0
            |-> min_q <= max_q)
            else $error("window extremes crossed");

         filt_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE4
            !last
            |=> $stable(lpf_q))
            else $error("filter moved outside publish slot");

         raw_pub_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE13
            raw_mode
            |=> res_q == {4'h0, $past(filt)})
            else $error("raw result not the filtered count");

         scaled_pub_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE6
            !raw_mode
            |=> res_q == $past(bcd))
            else $error("scaled result not the BCD value");

         code_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE17
            !raw_mode
            |-> code <= adc_readout_pkg::SCALE_MAX_CODE)
            else $error("undefined scale code in use");
      end
   endgenerate

   // Settings set: one byte, validated writes
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scale_q <= adc_readout_pkg::SCALE_SEL_RESET; // RULE14
         set_rdata_q <= 8'h00;
         set_rvalid_q <= 1'b0;
      end else begin
         if (scale_we) begin
            scale_q <= i_set_req.wdata; // RULE8
         end
         set_rvalid_q <= i_set_req.rd;
         set_rdata_q <= (i_set_req.rd && set_sel) ? scale_q : 8'h00; // RULE8
      end
   end

   // Status set: read only, writes have no path here
   wire [15:0] stat_mux = (i_stat_req.addr == adc_readout_pkg::CH0_RESULT_OFFSET) ? result_w[0] :
                          (i_stat_req.addr == adc_readout_pkg::CH1_RESULT_OFFSET) ? result_w[1] :
                          (i_stat_req.addr == adc_readout_pkg::CH2_RESULT_OFFSET) ? result_w[2] : 16'h0000; // RULE2

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_rdata_q <= 16'h0000;
         stat_rvalid_q <= 1'b0;
      end else begin
         stat_rvalid_q <= i_stat_req.rd;
         stat_rdata_q <= i_stat_req.rd ? stat_mux : 16'h0000; // RULE16
      end
   end

   assign o_conv_start = start_q;
   assign o_conv_chan = chan_q;
   assign o_set_rdata = set_rdata_q;
   assign o_set_rvalid = set_rvalid_q;
   assign o_stat_rdata = stat_rdata_q;
   assign o_stat_rvalid = stat_rvalid_q;

   // Assertions
   sample_pace_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      tick_q < 32'(adc_readout_pkg::SAMPLE_CYCLES)) else $error("sample pacing counter overran");

   start_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      o_conv_start |=> !o_conv_start) else $error("conversion start longer than one cycle");

   chan_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
      o_conv_chan < 2'(adc_readout_pkg::NUM_CH)) else $error("channel index out of range");

   bad_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE17
      (i_set_req.wr && set_sel && !code_raw && !code_ok) |=> $stable(scale_q)) else $error("bad scale code stored");

   good_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE11
      (i_set_req.wr && set_sel && code_ok) |=> scale_q == $past(i_set_req.wdata)) else $error("scale write lost");

   scale_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
      (i_set_req.rd && set_sel && !scale_we) |=> o_set_rdata == $past(scale_q)) else $error("scale readback wrong");

   ch0_base_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE7
      g_ch[0].fs == adc_readout_pkg::FS_5V2) else $error("channel zero left base scale");

   raw_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE13
      (raw_mode && i_stat_req.rd) |=> o_stat_rdata[15:12] == 4'h0) else $error("raw result above 12 bits");

   bcd_digit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE6
      !raw_mode |-> g_ch[0].bcd[3:0] <= 4'h9) else $error("non-BCD digit in result");

   // Settings set answers
   set_answer_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
      i_set_req.rd
      |=> o_set_rvalid)
      else $error("settings read not answered");

   set_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
      !i_set_req.rd
      |=> !o_set_rvalid && o_set_rdata == 8'h00)
      else $error("settings answer without a read");

   set_other_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
      i_set_req.rd && !set_sel
      |=> o_set_rdata == 8'h00)
      else $error("unmapped settings read not zero");

   raw_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE12
      i_set_req.wr && set_sel && code_raw
      |=> raw_mode)
      else $error("raw code not taken");

   other_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE8
      i_set_req.wr && !set_sel
      |=> $stable(scale_q))
      else $error("write to other offset changed scale");

   // Status set answers
   stat_answer_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE16
      i_stat_req.rd
      |=> o_stat_rvalid)
      else $error("status read not answered");

   stat_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE16
      !i_stat_req.rd
      |=> !o_stat_rvalid && o_stat_rdata == 16'h0000)
      else $error("status answer without a read");

   ch0_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      i_stat_req.rd && i_stat_req.addr == adc_readout_pkg::CH0_RESULT_OFFSET
      |=> o_stat_rdata == $past(result_w[0]))
      else $error("channel zero read wrong");

   ch1_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      i_stat_req.rd && i_stat_req.addr == adc_readout_pkg::CH1_RESULT_OFFSET
      |=> o_stat_rdata == $past(result_w[1]))
      else $error("channel one read wrong");

   ch2_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      i_stat_req.rd && i_stat_req.addr == adc_readout_pkg::CH2_RESULT_OFFSET
      |=> o_stat_rdata == $past(result_w[2]))
      else $error("channel two read wrong");

   unmapped_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      i_stat_req.rd && i_stat_req.addr != adc_readout_pkg::CH0_RESULT_OFFSET &&
      i_stat_req.addr != adc_readout_pkg::CH1_RESULT_OFFSET && i_stat_req.addr != adc_readout_pkg::CH2_RESULT_OFFSET
      |=> o_stat_rdata == 16'h0000)
      else $error("unmapped status read not zero");

   // Conversion sequencing
   slot_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      state_q == S_IDLE && period_tick
      |=> o_conv_start && o_conv_chan == 2'h0)
      else $error("slot did not start on channel zero");

   next_chan_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
      state_q == S_WAIT && i_conv_done && chan_q != 2'(adc_readout_pkg::NUM_CH - 1)
      |=> o_conv_start && o_conv_chan == $past(chan_q) + 2'h1)
      else $error("next channel not started");

   slot_end_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      state_q == S_WAIT && i_conv_done && chan_q == 2'(adc_readout_pkg::NUM_CH - 1)
      |=> state_q == S_IDLE && !o_conv_start)
      else $error("slot did not close after last channel");

   wait_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      state_q == S_WAIT
      |-> !o_conv_start)
      else $error("start raised while converting");

   chan_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
      state_q == S_WAIT && !i_conv_done
      |=> $stable(o_conv_chan))
      else $error("channel moved during conversion");

   tick_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      period_tick
      |=> tick_q == 32'h0)
      else $error("pacing counter did not wrap");
endmodule
`default_nettype wire

// *** test/adc_conv_model.sv ***
// Behavioural converter answering start pulses with per-channel counts
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Converter handshake
   input wire logic i_conv_start,
   input wire logic [1:0] i_conv_chan,
   input wire logic i_slow,
   output logic o_conv_done,
   output logic [11:0] o_conv_data
);
   int unsigned wait_q;
   logic busy_q;
   logic [1:0] chan_q;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_q <= 1'b0;
         wait_q <= 0;
         chan_q <= 2'h0;
         o_conv_done <= 1'b0;
         o_conv_data <= 12'h000;
      end else begin
         o_conv_done <= 1'b0;
         // Stale data must not look valid outside done
         o_conv_data <= ~o_conv_data;
         if (i_conv_start) begin
            busy_q <= 1'b1;
            chan_q <= i_conv_chan;
            wait_q <= i_slow ? 700 : 2;
         end else if (busy_q && wait_q != 0) begin
            wait_q <= wait_q - 1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            o_conv_done <= 1'b1;
            o_conv_data <= {chan_q, 10'h2a5};
         end
      end
   end
endmodule
`default_nettype wire

// *** test/adc_scaled_readout_test.sv ***
// Self-checking bench for the scaled ADC readout registers
`timescale 1ns/1ps
`default_nettype none
module adc_scaled_readout_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b1;
   adc_readout_pkg::settings_req_t set_req = '0;
   adc_readout_pkg::status_req_t stat_req = '0;
   logic conv_start, conv_done, set_rvalid, stat_rvalid;
   logic [1:0] conv_chan;
   logic [1:0] exp_chan = 2'h0;
   logic [11:0] conv_data;
   logic [7:0] set_rdata, scale;
   logic [15:0] stat_rdata;
   logic [15:0] set_q[$];
   logic [15:0] stat_q[$];
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int convs = 0;

   always #2.5 clk = ~clk;

   adc_scaled_readout dut (.i_core_clk(clk), .i_rst_n(rst_n), .o_conv_start(conv_start), .o_conv_chan(conv_chan),
      .i_conv_done(conv_done), .i_conv_data(conv_data), .i_set_req(set_req), .o_set_rdata(set_rdata),
      .o_set_rvalid(set_rvalid), .i_stat_req(stat_req), .o_stat_rdata(stat_rdata), .o_stat_rvalid(stat_rvalid));
   adc_conv_model conv (.i_core_clk(clk), .i_rst_n(rst_n), .i_conv_start(conv_start), .i_conv_chan(conv_chan),
      .i_slow(slow), .o_conv_done(conv_done), .o_conv_data(conv_data));

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic set_acc(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] data,
      input logic [7:0] exp);
      if (rd) set_q.push_back({8'h00, exp});
      @(posedge clk);
      set_req <= '{wr: wr, rd: rd, addr: addr, wdata: data};
      @(posedge clk);
      set_req <= '0;
   endtask

   task automatic stat_rd(input logic [7:0] addr, input logic [15:0] exp);
      stat_q.push_back(exp);
      @(posedge clk);
      stat_req <= '{rd: 1'b1, addr: addr};
      @(posedge clk);
      stat_req <= '0;
   endtask

   // Same-cycle read must still see the old byte
   task automatic scale_wr(input logic [7:0] v);
      set_acc(1'b1, 1'b1, 8'h08, v, scale);
      if (v == 8'hff || (v[7:4] <= 4'h3 && v[3:0] <= 4'h3)) scale = v;
      set_acc(1'b0, 1'b1, 8'h08, 8'h00, scale);
   endtask

   // Results expected in order of the requests
   always @(posedge clk) begin
      cycles++;
      if (set_rvalid === 1'b1) check({8'h00, set_rdata}, set_q.size() ? set_q.pop_front() : 16'hxxxx);
      else check({8'h00, set_rdata}, 16'h0000);
      if (stat_rvalid === 1'b1) check(stat_rdata, stat_q.size() ? stat_q.pop_front() : 16'hxxxx);
      if (conv_start === 1'b1) begin
         check({14'h0, conv_chan}, {14'h0, exp_chan});
         exp_chan <= exp_chan == 2'h2 ? 2'h0 : exp_chan + 2'h1;
         convs++;
      end
      if (cycles == 80000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      void'($urandom(54));
      scale = 8'h00;
      slow = 1'($urandom_range(0, 1));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      set_acc(1'b0, 1'b1, 8'h08, 8'h00, 8'h00);
      stat_rd(8'h14, 16'h0000);
      stat_rd(8'h16, 16'h0000);
      stat_rd(8'h18, 16'h0000);
      stat_rd(8'h1a, 16'h0000);
      set_acc(1'b1, 1'b0, 8'h14, 8'h33, 8'h00);
      set_acc(1'b1, 1'b1, 8'h09, 8'h12, 8'h00);
      set_acc(1'b0, 1'b1, 8'h08, 8'h00, 8'h00);
      for (int i = 0; i < 16; i++) scale_wr({2'b00, 2'(i >> 2), 2'b00, 2'(i)});
      scale_wr(8'hff);
      scale_wr(8'h40);
      scale_wr(8'h04);
      scale_wr(8'h00);
      for (int i = 0; i < 24; i++) begin
         scale_wr(i % 6 == 5 ? 8'hff : {4'($urandom_range(0, 4)), 4'($urandom_range(0, 4))});
         stat_rd(8'($urandom_range(0, 255)), 16'h0000);
      end
      for (int i = 0; i < 60000 && convs < 3; i++) @(posedge clk);
      repeat (720) @(posedge clk);
      check(16'(convs), 16'h0003);
      repeat (3) @(posedge clk);
      if (set_q.size() + stat_q.size() != 0) miscompares++;
      end_of_test();
   end
endmodule
`default_nettype wire
